// ===== swr_wake.sv
`timescale 1ns/1ps
`default_nettype none
`include "swr_cfg.svh"

module swr_wake (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port2Pins,
  input wire logic [3:0] port3Pins,
  input wire logic [1:0] port0Pins,
  input wire logic [7:0] port2IsOutput,
  input wire logic [3:0] port3IsOutput,
  input wire logic [1:0] port0IsOutput,
  input wire logic port2DataRead,
  input wire logic port2DataWrite,
  input wire logic [7:0] port2DataValue,
  input wire logic legacyWakeEvent,
  output logic wakeRequest,
  output logic irq
);

  // every flop of the block sits in this one struct; stateNext is what the next edge loads
  swr_pkg::swr_state_type stateReg;
  swr_pkg::swr_state_type stateNext;

  // byte address of a register from its index
  function automatic logic [15:0] regAddr(input logic [15:0] idx);
    regAddr = {idx[13:0], 2'b00};
  endfunction

  // neutral input for a NAND is one, for a NOR zero
  // a NAND of nothing reads zero and a NOR of nothing one, which the level bit then compares
  function automatic logic gatePins(input logic [7:0] pins, input logic [7:0] use_, input logic isNand);
    logic [7:0] masked;
    masked = isNand ? (pins | ~use_) : (pins & use_);
    gatePins = isNand ? ~(&masked) : ~(|masked);
  endfunction

  // helper nets, all derived from stateReg and the inputs within one cycle
  logic setupPhase;
  logic accessDone;
  logic writeDone;
  logic [1:0] statNow;
  logic refValid;
  logic [7:0] p2Events;
  logic p2Wake;
  logic [7:0] p2Usable;
  logic [3:0] p3Usable;
  logic [1:0] p0Usable;
  logic gateOut;
  logic gatedWake;
  logic anyWake;
  logic refCapture;
  logic [31:0] readData;
  logic addrHit;
  swr_pkg::swr_src_type srcCode;
  logic srcValid;

  // apb phase decode
  // a write lands only at the edge that completes the access, never in setup
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & stateReg.pready;
  assign writeDone = accessDone & pwrite;

  // reference is in use only while the status field names a read or a write;
  // 11 is reserved and keeps the low-level default rather than a stale reference
  assign statNow = stateReg.refStatus;
  always_comb begin
    unique case (statNow)
      `SWR_STAT_READ: refValid = 1'b1;
      `SWR_STAT_WRITE: refValid = 1'b1;
      default: refValid = 1'b0;
    endcase
  end

  // per-pin comparison on the filtered levels
  // one reference byte serves all pins; unselected bits simply never fire
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (refValid) begin
        p2Events[i] = stateReg.port2Sel[i] & (stateReg.p2Level[i] != stateReg.refValue[i]);
      end else begin
        p2Events[i] = stateReg.port2Sel[i] & ~stateReg.p2Level[i];
      end
    end
  end
  assign p2Wake = |p2Events;

  // pins usable by the gate: inputs not claimed by a per-pin selection
  assign p2Usable = ~port2IsOutput & ~stateReg.port2Sel;
  assign p3Usable = ~port3IsOutput & ~stateReg.port3Sel;
  // port 0 has no per-pin selection here, so only its direction can take it out
  assign p0Usable = ~port0IsOutput;

  // the field may hold 111, which has no enum name; the cast keeps the raw code
  assign srcCode = swr_pkg::swr_src_type'(stateReg.gatedSel[`SWR_GATED_SRC_MSB:`SWR_GATED_SRC_LSB]);

  // 000 and the unused 111 raise nothing, whatever the level bit says
  assign srcValid = (srcCode != swr_pkg::SRC_NONE) &&
                    (stateReg.gatedSel[`SWR_GATED_SRC_MSB:`SWR_GATED_SRC_LSB] != 3'h7);

  // gate-combination selector; 111 selects nothing
  always_comb begin
    gateOut = 1'b0;
    gatedWake = 1'b0;
    // excluded pins enter each gate at its neutral value, see gatePins
    unique case (srcCode)
      swr_pkg::SRC_NONE: begin
        gateOut = 1'b0;
      end
      swr_pkg::SRC_NAND_P2LO: begin
        gateOut = gatePins({4'h0, stateReg.p2Level[3:0]}, {4'h0, p2Usable[3:0]}, 1'b1);
      end
      swr_pkg::SRC_NAND_P2ALL: begin
        gateOut = gatePins(stateReg.p2Level, p2Usable, 1'b1);
      end
      swr_pkg::SRC_NOR_P3: begin
        gateOut = gatePins({5'h00, stateReg.p3Level[3:1]}, {5'h00, p3Usable[3:1]}, 1'b0);
      end
      swr_pkg::SRC_NAND_P3: begin
        gateOut = gatePins({5'h00, stateReg.p3Level[3:1]}, {5'h00, p3Usable[3:1]}, 1'b1);
      end
      swr_pkg::SRC_NOR_P3P0: begin
        gateOut = gatePins({3'h0, stateReg.p3Level[3:1], stateReg.p0Level},
                           {3'h0, p3Usable[3:1], p0Usable}, 1'b0);
      end
      swr_pkg::SRC_NAND_P3P2: begin
        gateOut = gatePins({2'h0, stateReg.p3Level[3:1], stateReg.p2Level[2:0]},
                           {2'h0, p3Usable[3:1], p2Usable[2:0]}, 1'b1);
      end
      default: begin
        // 111 is not a mode; the gate output is parked low and srcValid blocks the event
        gateOut = 1'b0;
      end
    endcase
    // compare against the programmed level; no source means no event
    if (srcValid) begin
      gatedWake = (gateOut == stateReg.gatedSel[`SWR_GATED_LEVEL_BIT]);
    end
  end

  // any source wakes; the legacy source arrives already qualified
  // the per-pin and gated paths are simply ORed, so either alone is enough
  assign anyWake = p2Wake | gatedWake | legacyWakeEvent;

  // capture only while at least one pin is selected
  // with nothing selected the data register is ignored, so stale values never arm a compare
  assign refCapture = (|stateReg.port2Sel) & (port2DataRead | port2DataWrite);

  // read mux and address decode
  // unmapped addresses read zero and answer with pslverr; no register changes
  always_comb begin
    readData = 32'h0000_0000;
    addrHit = 1'b1;
    unique case (paddr)
      regAddr(`SWR_IDX_WAKE_STATUS_CTRL): readData[1:0] = stateReg.refStatus;
      regAddr(`SWR_IDX_PORT2_WAKE_SELECT): readData[7:0] = stateReg.port2Sel;
      regAddr(`SWR_IDX_GATED_WAKE_SELECT): readData[7:0] = stateReg.gatedSel;
      regAddr(`SWR_IDX_PORT3_WAKE_SELECT): readData[3:0] = stateReg.port3Sel;
      regAddr(`SWR_IDX_IRQ_STATUS): readData[1:0] = stateReg.irqStatus;
      regAddr(`SWR_IDX_IRQ_MASK): readData[1:0] = stateReg.irqMask;
      default: addrHit = 1'b0;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    stateNext = stateReg;

    // three-stage pin synchronisers; a change counts once stages two and three agree
    // stage one feeds stage two only, so a metastable value never reaches the compare
    stateNext.p2Sync1 = port2Pins;
    stateNext.p2Sync2 = stateReg.p2Sync1;
    stateNext.p2Sync3 = stateReg.p2Sync2;
    stateNext.p3Sync1 = port3Pins;
    stateNext.p3Sync2 = stateReg.p3Sync1;
    stateNext.p3Sync3 = stateReg.p3Sync2;
    stateNext.p0Sync1 = port0Pins;
    stateNext.p0Sync2 = stateReg.p0Sync1;
    stateNext.p0Sync3 = stateReg.p0Sync2;
    for (int i = 0; i < 8; i++) begin
      if (stateReg.p2Sync2[i] == stateReg.p2Sync3[i]) begin
        stateNext.p2Level[i] = stateReg.p2Sync3[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (stateReg.p3Sync2[i] == stateReg.p3Sync3[i]) begin
        stateNext.p3Level[i] = stateReg.p3Sync3[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (stateReg.p0Sync2[i] == stateReg.p0Sync3[i]) begin
        stateNext.p0Level[i] = stateReg.p0Sync3[i];
      end
    end

    // apb answer: one wait-free access phase, registered response
    // an abandoned setup still gets its single ready pulse; nothing is written without penable
    stateNext.pready = 1'b0;
    stateNext.pslverr = 1'b0;
    if (setupPhase) begin
      stateNext.pready = 1'b1;
      stateNext.pslverr = ~addrHit;
      stateNext.prdata = pwrite ? 32'h0000_0000 : readData;
    end

    // register writes take effect at the completing access edge
    if (writeDone && addrHit) begin
      unique case (paddr)
        regAddr(`SWR_IDX_WAKE_STATUS_CTRL): begin
          // any code may be written; a capture in the same cycle overrides it below
          stateNext.refStatus = pwdata[`SWR_STAT_MSB:`SWR_STAT_LSB];
        end
        regAddr(`SWR_IDX_PORT2_WAKE_SELECT): begin
          // a pin must already be an input; the direction is not checked here
          stateNext.port2Sel = pwdata[7:0];
        end
        regAddr(`SWR_IDX_GATED_WAKE_SELECT): begin
          // reserved bits are dropped, software is expected to write zero
          stateNext.gatedSel = pwdata[7:0] & `SWR_GATED_WRITE_MASK;
        end
        regAddr(`SWR_IDX_PORT3_WAKE_SELECT): begin
          // only used to take port 3 pins out of the gates
          stateNext.port3Sel = pwdata[3:0];
        end
        regAddr(`SWR_IDX_IRQ_STATUS): begin
          // write one to clear; a same-cycle event is set again below
          stateNext.irqStatus = stateReg.irqStatus & ~pwdata[`SWR_IRQ_WIDTH-1:0];
        end
        regAddr(`SWR_IDX_IRQ_MASK): begin
          stateNext.irqMask = pwdata[`SWR_IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // a data-register access in the same cycle as the status write wins, so a capture is never lost
    if (refCapture) begin
      stateNext.refValue = port2DataValue;
      stateNext.refStatus = port2DataWrite ? `SWR_STAT_WRITE : `SWR_STAT_READ;
    end

    // sticky events: set beats a same-cycle clear
    if (anyWake) begin
      stateNext.irqStatus[`SWR_IRQ_WAKE_BIT] = 1'b1;
    end
    if (refCapture) begin
      stateNext.irqStatus[`SWR_IRQ_REF_BIT] = 1'b1;
    end

    // registered so the request leaves the block glitch-free, at the cost of one cycle
    stateNext.wake = anyWake;
    // irq follows the updated status, so a clear drops it at the same edge as the write
    stateNext.irq = |(stateNext.irqStatus & stateNext.irqMask);
  end

  // single state register; there is no wake-time reset, only power-on srst
  // the synchronisers restart from zero; with nothing selected no false event follows
  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= '0;
      stateReg.port2Sel <= `SWR_RST_PORT2_SEL;
      stateReg.gatedSel <= `SWR_RST_GATED_SEL;
      stateReg.port3Sel <= `SWR_RST_PORT3_SEL;
      stateReg.refStatus <= `SWR_RST_STATUS;
      stateReg.refValue <= `SWR_RST_REF;
    end else begin
      stateReg <= stateNext;
    end
  end

  // outputs straight from the state flops
  // nothing combinational reaches a port, so the far side sees clean levels
  assign prdata = stateReg.prdata;
  assign pready = stateReg.pready;
  assign pslverr = stateReg.pslverr;
  assign wakeRequest = stateReg.wake;
  assign irq = stateReg.irq;

endmodule
`default_nettype wire

// ===== swr_cfg.svh
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH

// register indices; byte address is four times the index
`define SWR_IDX_WAKE_STATUS_CTRL 16'h0F0A
`define SWR_IDX_PORT2_WAKE_SELECT 16'h0F0C
`define SWR_IDX_GATED_WAKE_SELECT 16'h0F0D
`define SWR_IDX_PORT3_WAKE_SELECT 16'h0F0E
`define SWR_IDX_IRQ_STATUS 16'h0F10
`define SWR_IDX_IRQ_MASK 16'h0F11

// gated_wake_select fields
`define SWR_GATED_LEVEL_BIT 6
`define SWR_GATED_SRC_MSB 4
`define SWR_GATED_SRC_LSB 2
`define SWR_GATED_WRITE_MASK 8'h5C

// wake_status_ctrl port 2 reference status field
`define SWR_STAT_MSB 1
`define SWR_STAT_LSB 0
`define SWR_STAT_NONE 2'h0
`define SWR_STAT_READ 2'h1
`define SWR_STAT_WRITE 2'h2

// interrupt status bits
`define SWR_IRQ_WAKE_BIT 0
`define SWR_IRQ_REF_BIT 1
`define SWR_IRQ_WIDTH 2

// reset values
`define SWR_RST_PORT2_SEL 8'h00
`define SWR_RST_GATED_SEL 8'h00
`define SWR_RST_PORT3_SEL 4'h0
`define SWR_RST_STATUS 2'h0
`define SWR_RST_REF 8'h00

`endif

// ===== swr_pkg.sv
package swr_pkg;

  // gate-combination source codes
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_NAND_P2LO = 3'h1,
    SRC_NAND_P2ALL = 3'h2,
    SRC_NOR_P3 = 3'h3,
    SRC_NAND_P3 = 3'h4,
    SRC_NOR_P3P0 = 3'h5,
    SRC_NAND_P3P2 = 3'h6
  } swr_src_type;

  // whole state of the wake block
  typedef struct packed {
    logic [7:0] port2Sel;
    logic [7:0] gatedSel;
    logic [3:0] port3Sel;
    logic [1:0] refStatus;
    logic [7:0] refValue;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [7:0] p2Sync1;
    logic [7:0] p2Sync2;
    logic [7:0] p2Sync3;
    logic [7:0] p2Level;
    logic [3:0] p3Sync1;
    logic [3:0] p3Sync2;
    logic [3:0] p3Sync3;
    logic [3:0] p3Level;
    logic [1:0] p0Sync1;
    logic [1:0] p0Sync2;
    logic [1:0] p0Sync3;
    logic [1:0] p0Level;
    logic wake;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } swr_state_type;

endpackage

// ===== swr_wake_checker.sv
`timescale 1ns/1ps
`default_nettype none
module swr_wake_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic legacyWakeEvent,
  input wire logic wakeRequest,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // zero wait states: the answer follows the setup cycle at once
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_hi; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  // the legacy source alone must raise the request one cycle on
  property p_leg; legacyWakeEvent |=> wakeRequest; endproperty
  a_leg: assert property (p_leg) else $error("legacy event lost");
  property p_fall; $fell(wakeRequest) |-> !$past(legacyWakeEvent); endproperty
  a_fall: assert property (p_fall) else $error("wake dropped with source");
  property p_rst; $fell(srst) |-> !wakeRequest && !irq && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule
bind swr_wake swr_wake_checker i_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .legacyWakeEvent(legacyWakeEvent), .wakeRequest(wakeRequest), .irq(irq));
`default_nettype wire

// ===== swr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module swr_pin_model (
  input wire logic clk,
  input wire logic [7:0] p2Want,
  input wire logic [3:0] p3Want,
  input wire logic [1:0] p0Want,
  output var logic [7:0] port2Pins,
  output var logic [3:0] port3Pins,
  output var logic [1:0] port0Pins
);
  // pins move well off the edge so the synchronisers see truly async changes
  initial begin
    port2Pins = 8'hFF;
    port3Pins = 4'h0;
    port0Pins = 2'h0;
    forever begin
      @(posedge clk);
      #7;
      port2Pins = p2Want;
      port3Pins = p3Want;
      port0Pins = p0Want;
    end
  end
endmodule
`default_nettype wire

// ===== stop_wake_event_sources_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swr_cfg.svh"
module stop_wake_event_sources_tb;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, legacyWakeEvent = 0;
  logic port2DataRead = 0, port2DataWrite = 0, pready, pslverr, wakeRequest, irq, lvl;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] p2Want = 8'hFF, port2IsOutput = '0, port2DataValue = '0, port2Pins;
  logic [3:0] p3Want = '0, port3IsOutput = '0, port3Pins;
  logic [1:0] p0Want = '0, port0IsOutput = '0, port0Pins;
  logic [2:0] code;
  logic [7:0] sel2 = '0;
  logic [3:0] sel3 = '0;
  logic [33:0] note;
  logic [33:0] q[$];
  int fail_count = 0, n_tests = 0;
  swr_wake i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port2Pins(port2Pins),
    .port3Pins(port3Pins), .port0Pins(port0Pins), .port2IsOutput(port2IsOutput), .port3IsOutput(port3IsOutput),
    .port0IsOutput(port0IsOutput), .port2DataRead(port2DataRead), .port2DataWrite(port2DataWrite),
    .port2DataValue(port2DataValue), .legacyWakeEvent(legacyWakeEvent), .wakeRequest(wakeRequest), .irq(irq));
  swr_pin_model i_pins (.clk(clk), .p2Want(p2Want), .p3Want(p3Want), .p0Want(p0Want),
    .port2Pins(port2Pins), .port3Pins(port3Pins), .port0Pins(port0Pins));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task hang;
    fail_count++;
    print_verdict();
  endtask
  // one apb transfer; the expected answer is noted before the request goes out
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic e);
    int k;
    q.push_back({!w, e, d});
    psel <= 1;
    pwrite <= w;
    paddr <= idx << 2;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // wait out the pin sync latency, then for the request to settle
  task ww(input logic exp);
    int k;
    k = 0;
    repeat (8) @(posedge clk);
    while (wakeRequest !== exp && k < 30) begin
      @(posedge clk);
      k++;
    end
    if (k >= 30) hang();
    chk({31'h0, wakeRequest}, {31'h0, exp});
  endtask
  task pulse(input logic rd, input logic [7:0] v);
    port2DataRead <= rd;
    port2DataWrite <= !rd;
    port2DataValue <= v;
    @(posedge clk);
    port2DataRead <= 0;
    port2DataWrite <= 0;
    @(posedge clk);
  endtask
  // output pins and per-pin selected pins count neutral: 1 into a nand, 0 into a nor
  function automatic logic gate(input logic [2:0] c);
    logic [7:0] a2;
    logic [3:0] a3;
    logic [3:0] o3;
    logic [1:0] o0;
    a2 = p2Want | port2IsOutput | sel2;
    a3 = p3Want | port3IsOutput | sel3;
    o3 = p3Want & ~port3IsOutput & ~sel3;
    o0 = p0Want & ~port0IsOutput;
    case (c)
      3'h1: gate = ~&a2[3:0];
      3'h2: gate = ~&a2;
      3'h3: gate = ~|o3[3:1];
      3'h4: gate = ~&a3[3:1];
      3'h5: gate = ~|{o3[3:1], o0};
      default: gate = ~&{a3[3:1], a2[2:0]};
    endcase
  endfunction
  // the monitor pairs each answer with the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) chk(prdata, note[31:0]);
    end
  end
  initial begin
    void'($urandom(85));
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    apb(0, `SWR_IDX_PORT2_WAKE_SELECT, '0, 0);
    apb(0, `SWR_IDX_GATED_WAKE_SELECT, '0, 0);
    apb(0, `SWR_IDX_WAKE_STATUS_CTRL, '0, 0);
    apb(0, 16'h0F20, '0, 1);
    apb(1, `SWR_IDX_PORT2_WAKE_SELECT, 32'h0000_0001, 0);
    ww(0);
    p2Want <= 8'hFE;
    ww(1);
    apb(0, `SWR_IDX_PORT2_WAKE_SELECT, 32'h0000_0001, 0);
    apb(1, `SWR_IDX_IRQ_MASK, 32'h0000_0001, 0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    p2Want <= 8'hFF;
    ww(0);
    apb(1, `SWR_IDX_IRQ_STATUS, 32'h0000_0001, 0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse(0, 8'h00);
    apb(0, `SWR_IDX_WAKE_STATUS_CTRL, 32'h0000_0002, 0);
    ww(1);
    p2Want <= 8'hFE;
    ww(0);
    pulse(1, 8'h01);
    apb(0, `SWR_IDX_WAKE_STATUS_CTRL, 32'h0000_0001, 0);
    ww(1);
    apb(1, `SWR_IDX_WAKE_STATUS_CTRL, '0, 0);
    p2Want <= 8'hFF;
    ww(0);
    p2Want <= 8'hFE;
    ww(1);
    apb(1, `SWR_IDX_PORT2_WAKE_SELECT, '0, 0);
    ww(0);
    legacyWakeEvent <= 1;
    ww(1);
    legacyWakeEvent <= 0;
    // every source code, random pins, levels and output masks
    for (int i = 0; i < 24; i++) begin
      code = 3'(i % 8);
      lvl = 1'($urandom);
      p2Want <= 8'($urandom);
      p3Want <= 4'($urandom);
      p0Want <= 2'($urandom);
      port2IsOutput <= 8'($urandom);
      port3IsOutput <= 4'($urandom);
      port0IsOutput <= 2'($urandom);
      apb(1, `SWR_IDX_GATED_WAKE_SELECT, {25'h0, lvl, 1'b0, code, 2'h0}, 0);
      // port 2 selections on inputs only, port 3 selections random; they also leave the gates
      sel2 = 8'($urandom) & ~port2IsOutput;
      sel3 = 4'($urandom);
      apb(1, `SWR_IDX_PORT2_WAKE_SELECT, {24'h00_0000, sel2}, 0);
      apb(1, `SWR_IDX_PORT3_WAKE_SELECT, {28'h000_0000, sel3}, 0);
      // gated event, or a selected pin still low: any source alone wakes
      ww((code != 3'h0 && code != 3'h7 && gate(code) == lvl) || (|(sel2 & ~p2Want)));
    end
    print_verdict();
  end
endmodule
`default_nettype wire
